//--- hw/sscr_pkg.sv
// constants and carrier types for the sensor status and configuration register bank
package sscr_pkg;
	// register word addresses
	localparam logic [7:0] ADDR_PRODUCT = 8'h00;
	localparam logic [7:0] ADDR_MAJOR = 8'h01;
	localparam logic [7:0] ADDR_MINOR = 8'h02;
	localparam logic [7:0] ADDR_RSV_LO = 8'h03;
	localparam logic [7:0] ADDR_RSV_HI = 8'h09;
	localparam logic [7:0] ADDR_STATUS = 8'h11;
	localparam logic [7:0] ADDR_SENSOR = 8'h20;
	localparam logic [7:0] ADDR_XFER = 8'h21;
	localparam logic [7:0] ADDR_METHOD = 8'h22;
	// identification values, arbitrary neutral values
	localparam logic [15:0] PRODUCT_VAL = 16'h0a5a;
	localparam logic [15:0] MAJOR_VAL = 16'h0001;
	localparam logic [15:0] MINOR_VAL = 16'h0001;
	// status bit positions
	localparam int ST_RESET = 7;
	localparam int ST_TUNE_ERR = 6;
	localparam int ST_TUNE_EVT = 5;
	localparam int ST_POWER = 4;
	localparam int ST_DIR = 3;
	localparam int ST_OUT = 2;
	localparam int ST_TOUCH = 1;
	localparam int ST_PROX = 0;
	localparam int ST_NEAR = 9;
	localparam int ST_CONTACT = 8;
	localparam int ST_TUNE_ACT = 13;
	// sensor setup bit positions
	localparam int SS_INVERT = 3;
	localparam int SS_DUAL = 2;
	localparam int SS_LINEAR = 1;
	localparam int SS_ENABLE = 0;
	localparam int SS_PIN_B = 9;
	localparam int SS_PIN_A = 8;
	// method control bit positions and codes
	localparam int MC_HALF_VOLT = 14;
	localparam int MC_CAP_SIZE = 12;
	localparam logic [5:0] METHOD_INDUCTIVE = 6'h3d;
	localparam logic [5:0] METHOD_SELF_CAP = 6'h10;
	// reset values (80 pF sample cap is the default)
	localparam logic [15:0] SENSOR_RST = 16'h0000;
	localparam logic [15:0] XFER_RST = 16'h007f;
	localparam logic [15:0] METHOD_RST = 16'h103d;
	// writable masks: reserved bits are held at zero
	localparam logic [15:0] SENSOR_WMASK = 16'h63ef;
	localparam logic [15:0] METHOD_WMASK = 16'h50ff;
	localparam logic [7:0] PERIOD_MAX = 8'h7f;
	// detection events from the sensing engine
	typedef struct packed {
		logic tune_error;
		logic tune_event;
		logic power_event;
		logic tune_active;
		logic near_raw;
		logic contact_raw;
	} sscr_evt_t;
	// configuration handed to the sensing engine
	typedef struct packed {
		logic chan_enable;
		logic invert;
		logic dual_dir;
		logic linearise;
		logic pin_a_en;
		logic pin_b_en;
		logic [7:0] xfer_period;
		logic [7:0] xfer_fraction;
		logic half_volt;
		logic cap_80pf;
		logic mode_inductive;
		logic mode_self_cap;
	} sscr_cfg_t;
endpackage

//--- hw/sscr_regs.sv
// sensor status and configuration register bank with word access port
`timescale 1ns/1ns
`default_nettype none
//
// Contract
// - identification words at 0x00-0x02 read fixed product and version values.
// - status bit 7 records that a reset occurred.
// - status bit 6 records an auto tuning error.
// - status bit 5 records an auto tuning event.
// - status bit 4 records a power mode event.
// - status bit 3 gives latest touch direction, 0 down, 1 up.
// - status bit 1 flags touch events, bit 0 flags proximity events.
// - proximity event bit stays separate from touch event bit.
// - sensor setup bit 3 inverts channel detection logic.
// - sensor setup bit 2 selects dual direction thresholds.
// - sensor setup bit 1 linearises measured counts.
// - sensor setup bit 0 enables measurement of the channel.
// - sampling setup holds period in bits 15-8 (0-127), fraction in 7-0.
// - fraction 127, period 0 gives 7.00 or 4.66 MHz with dead-time.
// - method control bit 14 enables the half volt discharge.
// - method control bit 12 picks 40 pF or default 80 pF capacitor.
// - method bits 5-0: 0x3D inductive, 0x10 self capacitance.
module sscr_regs
	import sscr_pkg::*;
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_ack_clear,
	input wire sscr_evt_t evt_in,
	output logic [15:0] reg_rdata,
	output logic reg_rvalid,
	output sscr_cfg_t cfg_out
);
	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	logic [15:0] sensor_ff;
	logic [15:0] xfer_ff;
	logic [15:0] method_ff;
	logic [7:0] sticky_ff;
	logic near_ff;
	logic contact_ff;
	logic tune_act_ff;
	logic [15:0] status_w;
	logic [15:0] nxt_rdata;
	logic near_det;
	logic contact_det;

	// write decode shared by all writable words
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
		return a == ref_a;
	endfunction

	// ------------------------------------------------------------
	// detection path
	// ------------------------------------------------------------
	// inversion and enable gate the raw detections
	always_comb begin
		near_det = (evt_in.near_raw ^ sensor_ff[SS_INVERT]) & sensor_ff[SS_ENABLE];
		contact_det = (evt_in.contact_raw ^ sensor_ff[SS_INVERT]) & sensor_ff[SS_ENABLE];
	end

	// live states follow detection every enabled cycle
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			near_ff <= 1'b0;
			contact_ff <= 1'b0;
			tune_act_ff <= 1'b0;
		end else if (clk_en) begin
			near_ff <= near_det;
			contact_ff <= contact_det;
			tune_act_ff <= evt_in.tune_active;
		end
	end

	// ------------------------------------------------------------
	// sticky event flags
	// ------------------------------------------------------------
	// flags set by events, set wins over clear
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			sticky_ff <= 8'h80; // reset event recorded at power-up
		end else if (clk_en) begin
			if (reg_ack_clear) begin
				sticky_ff[ST_RESET] <= 1'b0;
				sticky_ff[ST_TUNE_ERR] <= evt_in.tune_error;
				sticky_ff[ST_TUNE_EVT] <= evt_in.tune_event;
				sticky_ff[ST_POWER] <= evt_in.power_event;
				sticky_ff[ST_TOUCH] <= contact_det != contact_ff;
				sticky_ff[ST_PROX] <= near_det != near_ff;
			end else begin
				sticky_ff[ST_TUNE_ERR] <= sticky_ff[ST_TUNE_ERR] | evt_in.tune_error;
				sticky_ff[ST_TUNE_EVT] <= sticky_ff[ST_TUNE_EVT] | evt_in.tune_event;
				sticky_ff[ST_POWER] <= sticky_ff[ST_POWER] | evt_in.power_event;
				sticky_ff[ST_TOUCH] <= sticky_ff[ST_TOUCH] | (contact_det != contact_ff);
				sticky_ff[ST_PROX] <= sticky_ff[ST_PROX] | (near_det != near_ff);
			end
			// direction: 0 on touch down, 1 on release
			if (contact_det != contact_ff) begin
				sticky_ff[ST_DIR] <= ~contact_det;
			end
			sticky_ff[ST_OUT] <= contact_det;
		end
	end

	// ------------------------------------------------------------
	// configuration words
	// ------------------------------------------------------------
	// sensor setup, reserved bits forced to zero
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			sensor_ff <= SENSOR_RST;
		end else if (clk_en && reg_wr && hit(reg_addr, ADDR_SENSOR)) begin
			sensor_ff <= reg_wdata & SENSOR_WMASK;
		end
	end

	// period clamped to its 0-127 range, fraction stored whole
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			xfer_ff <= XFER_RST;
		end else if (clk_en && reg_wr && hit(reg_addr, ADDR_XFER)) begin
			xfer_ff[7:0] <= reg_wdata[7:0];
			xfer_ff[15:8] <= (reg_wdata[15:8] > PERIOD_MAX) ? PERIOD_MAX : reg_wdata[15:8];
		end
	end

	// method control, 80 pF by default
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			method_ff <= METHOD_RST;
		end else if (clk_en && reg_wr && hit(reg_addr, ADDR_METHOD)) begin
			method_ff <= reg_wdata & METHOD_WMASK;
		end
	end

	// configuration toward the engine, registered so outputs come from flops
	// the engine derives 7.00 or 4.66 MHz from period and fraction
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cfg_out <= '0;
		end else if (clk_en) begin
			cfg_out.chan_enable <= sensor_ff[SS_ENABLE];
			cfg_out.invert <= sensor_ff[SS_INVERT];
			cfg_out.dual_dir <= sensor_ff[SS_DUAL];
			cfg_out.linearise <= sensor_ff[SS_LINEAR];
			cfg_out.pin_a_en <= sensor_ff[SS_PIN_A];
			cfg_out.pin_b_en <= sensor_ff[SS_PIN_B];
			cfg_out.xfer_period <= xfer_ff[15:8];
			cfg_out.xfer_fraction <= xfer_ff[7:0];
			cfg_out.half_volt <= method_ff[MC_HALF_VOLT];
			cfg_out.cap_80pf <= method_ff[MC_CAP_SIZE];
			cfg_out.mode_inductive <= method_ff[5:0] == METHOD_INDUCTIVE;
			cfg_out.mode_self_cap <= method_ff[5:0] == METHOD_SELF_CAP;
		end
	end

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	// live bits sit apart from sticky low byte
	always_comb begin
		status_w = {2'b00, tune_act_ff, 3'b000, near_ff, contact_ff, sticky_ff};
	end

	// identification, status and configuration words; reserved and unmapped read zero
	always_comb begin
		nxt_rdata = 16'h0000;
		if (hit(reg_addr, ADDR_PRODUCT)) begin
			nxt_rdata = PRODUCT_VAL;
		end else if (hit(reg_addr, ADDR_MAJOR)) begin
			nxt_rdata = MAJOR_VAL;
		end else if (hit(reg_addr, ADDR_MINOR)) begin
			nxt_rdata = MINOR_VAL;
		end else if (hit(reg_addr, ADDR_STATUS)) begin
			nxt_rdata = status_w;
		end else if (hit(reg_addr, ADDR_SENSOR)) begin
			nxt_rdata = sensor_ff;
		end else if (hit(reg_addr, ADDR_XFER)) begin
			nxt_rdata = xfer_ff;
		end else if (hit(reg_addr, ADDR_METHOD)) begin
			nxt_rdata = method_ff;
		end
	end

	// read data one cycle after the strobe
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= 16'h0000;
			reg_rvalid <= 1'b0;
		end else if (clk_en) begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				reg_rdata <= nxt_rdata;
			end
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_id_read: assert property (@(posedge clk_sys) disable iff (!arst_n)
		clk_en && reg_rd && reg_addr == ADDR_PRODUCT |=> reg_rdata == PRODUCT_VAL)
		else $error("product word wrong");
	a_rsv_read: assert property (@(posedge clk_sys) disable iff (!arst_n)
		clk_en && reg_rd && reg_addr >= ADDR_RSV_LO && reg_addr <= ADDR_RSV_HI
		|=> reg_rdata == 16'h0000)
		else $error("reserved word not zero");
	a_tune_err_set: assert property (@(posedge clk_sys) disable iff (!arst_n)
		clk_en && evt_in.tune_error |=> sticky_ff[ST_TUNE_ERR])
		else $error("tuning error flag lost");
	a_tune_evt_set: assert property (@(posedge clk_sys) disable iff (!arst_n)
		clk_en && evt_in.tune_event |=> sticky_ff[ST_TUNE_EVT])
		else $error("tuning event flag lost");
	a_power_set: assert property (@(posedge clk_sys) disable iff (!arst_n)
		clk_en && evt_in.power_event |=> sticky_ff[ST_POWER])
		else $error("power event flag lost");
	a_reset_clr: assert property (@(posedge clk_sys) disable iff (!arst_n)
		clk_en && reg_ack_clear |=> !sticky_ff[ST_RESET])
		else $error("reset flag not cleared");
	a_touch_dir: assert property (@(posedge clk_sys) disable iff (!arst_n)
		clk_en && contact_det && !contact_ff |=> !sticky_ff[ST_DIR] && sticky_ff[ST_TOUCH])
		else $error("touch down not recorded");
	a_prox_sep: assert property (@(posedge clk_sys) disable iff (!arst_n)
		clk_en && near_det != near_ff |=> sticky_ff[ST_PROX])
		else $error("proximity event lost");
	a_chan_off: assert property (@(posedge clk_sys) disable iff (!arst_n)
		clk_en && !sensor_ff[SS_ENABLE] |=> !near_ff && !contact_ff)
		else $error("disabled channel detects");
	a_period_rng: assert property (@(posedge clk_sys) disable iff (!arst_n)
		xfer_ff[15:8] <= PERIOD_MAX)
		else $error("period out of range");
	a_method_cfg: assert property (@(posedge clk_sys) disable iff (!arst_n)
		clk_en && method_ff[5:0] == METHOD_INDUCTIVE ##1 clk_en |-> cfg_out.mode_inductive)
		else $error("inductive mode not decoded");
	a_rd_answer: assert property (@(posedge clk_sys) disable iff (!arst_n)
		clk_en && reg_rd |=> reg_rvalid)
		else $error("read answer missing");
	a_rd_quiet: assert property (@(posedge clk_sys) disable iff (!arst_n)
		clk_en && !reg_rd |=> !reg_rvalid)
		else $error("answer without a read");
	a_major_read: assert property (@(posedge clk_sys) disable iff (!arst_n)
		clk_en && reg_rd && reg_addr == ADDR_MAJOR |=> reg_rdata == MAJOR_VAL)
		else $error("major version word wrong");
	a_minor_read: assert property (@(posedge clk_sys) disable iff (!arst_n)
		clk_en && reg_rd && reg_addr == ADDR_MINOR |=> reg_rdata == MINOR_VAL)
		else $error("minor version word wrong");
	a_status_read: assert property (@(posedge clk_sys) disable iff (!arst_n)
		clk_en && reg_rd && reg_addr == ADDR_STATUS |=> reg_rdata == $past(status_w))
		else $error("status word wrong");
	a_live_track: assert property (@(posedge clk_sys) disable iff (!arst_n)
		clk_en |=> near_ff == $past(near_det) && contact_ff == $past(contact_det))
		else $error("live state lags detection");
	a_touch_up: assert property (@(posedge clk_sys) disable iff (!arst_n)
		clk_en && !contact_det && contact_ff |=> sticky_ff[ST_DIR] && sticky_ff[ST_TOUCH])
		else $error("touch release not recorded");
	a_invert_on: assert property (@(posedge clk_sys) disable iff (!arst_n)
		clk_en && sensor_ff[SS_ENABLE] && sensor_ff[SS_INVERT] && !evt_in.near_raw
		|=> near_ff)
		else $error("inverted channel not detecting");
	a_prox_clear: assert property (@(posedge clk_sys) disable iff (!arst_n)
		clk_en && reg_ack_clear && near_det == near_ff |=> !sticky_ff[ST_PROX])
		else $error("proximity flag not cleared");
	a_reset_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
		clk_en && !reg_ack_clear && sticky_ff[ST_RESET] |=> sticky_ff[ST_RESET])
		else $error("reset flag lost");
	a_sensor_wr: assert property (@(posedge clk_sys) disable iff (!arst_n)
		clk_en && reg_wr && reg_addr == ADDR_SENSOR
		|=> sensor_ff == ($past(reg_wdata) & SENSOR_WMASK))
		else $error("sensor setup write lost");
	a_dual_cfg: assert property (@(posedge clk_sys) disable iff (!arst_n)
		clk_en |=> cfg_out.dual_dir == $past(sensor_ff[SS_DUAL]))
		else $error("dual direction not handed on");
	a_linear_cfg: assert property (@(posedge clk_sys) disable iff (!arst_n)
		clk_en |=> cfg_out.linearise == $past(sensor_ff[SS_LINEAR]))
		else $error("linearise not handed on");
	a_xfer_cfg: assert property (@(posedge clk_sys) disable iff (!arst_n)
		clk_en |=> {cfg_out.xfer_period, cfg_out.xfer_fraction} == $past(xfer_ff))
		else $error("transfer timing not handed on");
	a_half_volt_cfg: assert property (@(posedge clk_sys) disable iff (!arst_n)
		clk_en |=> cfg_out.half_volt == $past(method_ff[MC_HALF_VOLT]))
		else $error("half volt discharge not handed on");
	a_cap_cfg: assert property (@(posedge clk_sys) disable iff (!arst_n)
		clk_en |=> cfg_out.cap_80pf == $past(method_ff[MC_CAP_SIZE]))
		else $error("capacitor size not handed on");
	a_self_cap_cfg: assert property (@(posedge clk_sys) disable iff (!arst_n)
		clk_en |=> cfg_out.mode_self_cap == ($past(method_ff[5:0]) == METHOD_SELF_CAP))
		else $error("self capacitance mode not decoded");
	// state frozen while the clock enable is low
	a_freeze_hold: assert property (@(posedge clk_sys) disable iff (!arst_n) // clock enable
		!clk_en |=> $stable(sensor_ff) && $stable(xfer_ff) && $stable(method_ff)
		&& $stable(sticky_ff))
		else $error("state moved with clock enable low");
endmodule
`default_nettype wire

//--- bench/sscr_host_model.sv
// host model driving the word access port of the register bank
`timescale 1ns/1ns
`default_nettype none
module sscr_host_model
	import sscr_pkg::*;
(
	input wire logic clk_sys,
	output logic [7:0] reg_addr,
	output logic reg_wr,
	output logic reg_rd,
	output logic [15:0] reg_wdata,
	output logic reg_ack_clear,
	input wire logic [15:0] reg_rdata,
	input wire logic reg_rvalid
);
	// idle bus at time zero
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 16'h0000;
		reg_ack_clear = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= (a == ADDR_SENSOR) ? (d & SENSOR_WMASK) : (a == ADDR_METHOD) ? (d & METHOD_WMASK) : d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		reg_wdata <= ~reg_wdata;
	endtask
	// read strobe, then a bounded wait for the answer
	task automatic rd(input logic [7:0] a, output logic [15:0] d, output bit ok);
		ok = 0;
		d = 16'h0000;
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		// the answer is taken at the edge that samples it high
		for (int i = 0; i < 4 && !ok; i++) begin
			@(posedge clk_sys);
			if (reg_rvalid === 1'b1) begin
				ok = 1;
				d = reg_rdata;
			end
		end
	endtask
	// one-cycle sticky flag clear
	task automatic ack();
		@(posedge clk_sys);
		reg_ack_clear <= 1'b1;
		@(posedge clk_sys);
		reg_ack_clear <= 1'b0;
	endtask
endmodule
`default_nettype wire

//--- bench/tb_top.sv
// self-checking bench for the sensor status and configuration register bank
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import sscr_pkg::*;
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic clk_en = 1'b1;
	sscr_evt_t evt_in = '0;
	logic [7:0] reg_addr;
	logic reg_wr, reg_rd, reg_ack_clear;
	logic [15:0] reg_wdata, reg_rdata;
	logic reg_rvalid;
	sscr_cfg_t cfg_out;
	int err_count = 0;
	int total_checks = 0;
	logic [31:0] seed = 32'h3a26_60d7;
	logic [15:0] d0, d1, d2, got;
	always #2 clk_sys = ~clk_sys;
	sscr_regs sscr_regs_inst(.clk_sys(clk_sys), .arst_n(arst_n), .clk_en(clk_en),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_ack_clear(reg_ack_clear), .evt_in(evt_in), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .cfg_out(cfg_out));
	sscr_host_model sscr_host_model_inst(.clk_sys(clk_sys), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_ack_clear(reg_ack_clear), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
	// ---------------------------------------------
	// checking and closing
	// ---------------------------------------------
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic final_report();
		if (err_count == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	// read a word, compare the bits under m; a lost answer ends the run
	task automatic rdc(input logic [7:0] a, input logic [15:0] exp, input logic [15:0] m);
		bit ok;
		sscr_host_model_inst.rd(a, got, ok);
		if (!ok) begin
			err_count++;
			final_report();
		end
		check("rdata", got & m, exp & m);
	endtask
	// drive one engine bit, then let detection settle
	task automatic ev(input int b, input logic v, input int n);
		@(posedge clk_sys);
		evt_in[b] <= v;
		repeat (n) @(posedge clk_sys);
	endtask
	// ---------------------------------------------
	// main sequence
	// ---------------------------------------------
	initial begin
		repeat (5) @(posedge clk_sys);
		arst_n <= 1'b1;
		for (int a = 0; a < 10; a++) begin
			d0 = (a == 0) ? PRODUCT_VAL : (a == 1) ? MAJOR_VAL : (a == 2) ? MINOR_VAL : 16'h0000;
			rdc(a[7:0], d0, 16'hffff);
		end
		rdc(ADDR_STATUS, 16'h0080, 16'h03ff);
		rdc(ADDR_METHOD, METHOD_RST, 16'hffff);
		sscr_host_model_inst.wr(ADDR_PRODUCT, 16'hffff);
		rdc(ADDR_PRODUCT, PRODUCT_VAL, 16'hffff);
		sscr_host_model_inst.ack();
		rdc(ADDR_STATUS, 16'h0000, 16'h00f3);
		// sticky engine flags: set by a pulse, gone after clear
		for (int b = 3; b < 6; b++) begin
			ev(b, 1'b1, 0);
			ev(b, 1'b0, 3);
			rdc(ADDR_STATUS, 16'h0001 << (b + 1), 16'h00f3);
			sscr_host_model_inst.ack();
			rdc(ADDR_STATUS, 16'h0000, 16'h00f3);
		end
		// proximity then touch on an enabled channel
		sscr_host_model_inst.wr(ADDR_SENSOR, 16'h0301);
		ev(1, 1'b1, 3);
		rdc(ADDR_STATUS, 16'h0201, 16'h0303);
		sscr_host_model_inst.ack();
		ev(0, 1'b1, 3);
		rdc(ADDR_STATUS, 16'h0306, 16'h030f);
		ev(0, 1'b0, 3);
		rdc(ADDR_STATUS, 16'h0200, 16'h0304);
		check("direction", {15'h0000, got[ST_DIR]}, 16'h0001);
		ev(1, 1'b0, 3);
		// inverted logic reports near and contact with both raw inputs low
		sscr_host_model_inst.wr(ADDR_SENSOR, 16'h0309);
		repeat (3) @(posedge clk_sys);
		rdc(ADDR_STATUS, 16'h0300, 16'h0300);
		sscr_host_model_inst.wr(ADDR_SENSOR, 16'h0308);
		sscr_host_model_inst.ack();
		ev(1, 1'b1, 3);
		rdc(ADDR_STATUS, 16'h0000, 16'h0303);
		ev(1, 1'b0, 1);
		// method codes and the 7 MHz setting first, then random words
		for (int i = 0; i < 12; i++) begin
			seed = xs(seed);
			d0 = seed[15:0];
			d1 = (i == 0) ? 16'h007f : seed[31:16];
			d2 = (i == 0) ? 16'h103d : (i == 1) ? 16'h4010 : seed[23:8];
			sscr_host_model_inst.wr(ADDR_SENSOR, d0);
			sscr_host_model_inst.wr(ADDR_XFER, d1);
			sscr_host_model_inst.wr(ADDR_METHOD, d2);
			if (d1[15:8] > 8'd127) d1[15:8] = 8'd127;
			rdc(ADDR_SENSOR, d0 & SENSOR_WMASK, 16'hffff);
			rdc(ADDR_XFER, d1, 16'hffff);
			rdc(ADDR_METHOD, d2 & METHOD_WMASK, 16'hffff);
			check("cfg_sensor", {10'h000, cfg_out.pin_b_en, cfg_out.pin_a_en, cfg_out.chan_enable,
				cfg_out.invert, cfg_out.dual_dir, cfg_out.linearise},
				{10'h000, d0[9], d0[8], d0[0], d0[3], d0[2], d0[1]});
			check("cfg_xfer", {cfg_out.xfer_period, cfg_out.xfer_fraction}, d1);
			check("cfg_method", {12'h000, cfg_out.half_volt, cfg_out.cap_80pf, cfg_out.mode_inductive,
				cfg_out.mode_self_cap}, {12'h000, d2[14], d2[12], d2[5:0] == 6'h3d,
				d2[5:0] == 6'h10});
		end
		// a write while the clock enable is low must be swallowed
		@(posedge clk_sys);
		clk_en <= 1'b0;
		sscr_host_model_inst.wr(ADDR_XFER, {1'b0, ~d1[14:0]});
		@(posedge clk_sys);
		clk_en <= 1'b1;
		rdc(ADDR_XFER, d1, 16'hffff);
		// live tuning activity follows its level
		ev(2, 1'b1, 3);
		rdc(ADDR_STATUS, 16'h2000, 16'h2000);
		ev(2, 1'b0, 3);
		rdc(ADDR_STATUS, 16'h0000, 16'h2000);
		// a reset in mid-run records itself and restores the defaults
		@(posedge clk_sys);
		arst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		arst_n <= 1'b1;
		rdc(ADDR_STATUS, 16'h0080, 16'h00f3);
		rdc(ADDR_XFER, XFER_RST, 16'hffff);
		rdc(ADDR_METHOD, METHOD_RST, 16'hffff);
		final_report();
	end
endmodule
`default_nettype wire
